// [rtl/clock_startup_map.vh]
`ifndef CLOCK_STARTUP_MAP_VH
`define CLOCK_STARTUP_MAP_VH

// Register byte offsets on the Wishbone slave.
`define FUSE_OFFSET        4'h0
`define PRESCALE_OFFSET    4'h4
`define CONTROL_OFFSET     4'h8
`define STATUS_OFFSET      4'hC

// Fuse register field positions; a fuse bit reads 0 when programmed.
`define FUSE_SRC_SEL_LSB   0
`define FUSE_STARTUP_LSB   4
`define FUSE_DIV8_BIT      6
`define FUSE_RSTDIS_BIT    7

// Shipped fuse image: select 0010, start-up 10, divide-by-eight programmed.
`define FUSE_SHIPPED       8'hA2

// Source select codes.
`define SRC_SEL_EXTERNAL   4'h0
`define SRC_SEL_RC8M       4'h2
`define SRC_SEL_OSC128K    4'h3
`define SRC_SEL_LF_XTAL    4'h4

// Prescaler select values loaded at reset, and the highest non-reserved select.
`define PRESCALE_DIV8      4'h3
`define PRESCALE_DIV1      4'h0
`define PRESCALE_MAX_SEL   4'h8

// Clock-cycle counts of the start-up phases.
`define CK_WAKE_6          16'h0006
`define CK_WAKE_258        16'h0102
`define CK_WAKE_1K         16'h0400
`define CK_WAKE_16K        16'h4000
`define CK_WAKE_32K        16'h8000
`define CK_RESET_14        16'h000E

// Watchdog oscillator cycles of the millisecond delays.
`define WDT_CYCLES_4MS     14'h0200
`define WDT_CYCLES_64MS    14'h2000

// Millisecond delay selections.
`define MS_NONE            2'h0
`define MS_4               2'h1
`define MS_64              2'h2

`endif

// [rtl/system_prescaler.v]
`timescale 1ns/10ps
`default_nettype none
`include "clock_startup_map.vh"

module system_prescaler (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       ce,
  input  wire       src_tick,
  input  wire [3:0] sel,
  output reg        tick_reg
);

  reg  [7:0] count_reg;
  wire [3:0] sel_eff;
  wire [7:0] last;
  wire [8:0] span;

  // Reserved selections above 8 fall back to the slowest division, 256.
  assign sel_eff = (sel > `PRESCALE_MAX_SEL) ? `PRESCALE_MAX_SEL : sel;
  assign span    = (9'h001 << sel_eff) - 9'h001;
  assign last    = span[7:0];

  // One division counter serves every clock domain, so all stay in step.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 8'h00;
      tick_reg  <= 1'b0;
    end else if (ce) begin
      tick_reg <= 1'b0;
      if (src_tick) begin
        if (count_reg >= last) begin
          count_reg <= 8'h00;
          tick_reg  <= 1'b1;
        end else begin
          count_reg <= count_reg + 8'h01;
        end
      end
    end
  end

endmodule // system_prescaler
`default_nettype wire

// [rtl/clock_source_startup_sequencer.v]
// Summary of operation
// - Select 0011 runs from 128 kHz oscillator.
// - 128 kHz: wake 6 CK, reset 14CK plus ms.
// - Reset pin disabled stretches shortest delay to 4ms.
// - Select 0100 runs from watch crystal.
// - Watch crystal wake and reset delays per code.
// - Upper select bits pick crystal frequency range.
// - Crystal, low select bit 0 delay table.
// - Crystal, low select bit 1 delay table.
// - Shipped fuses: 0010, code 10, divide-by-eight.
// - Prescaler divides all domain clocks equally.
// - Millisecond delays counted on watchdog oscillator.
// - Prescaler field resets to 0011 or 0000.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "clock_startup_map.vh"

module clock_source_startup_sequencer (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        osc128k_tick,
  input  wire        lf_xtal_tick,
  input  wire        xtal_tick,
  input  wire        rc8m_tick,
  input  wire        ext_clk_tick,
  input  wire        wdt_osc_tick,
  input  wire        wake_req,
  output wire        core_stall,
  output wire [1:0]  xtal_range,
  output wire        core_domain_clock,
  output wire        io_domain_clock,
  output wire        converter_domain_clock,
  output wire        program_memory_domain_clock
);

  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_CK  = 2'b01;
  localparam [1:0] ST_MS  = 2'b10;

  reg  [7:0]  fuse_reg;
  reg  [3:0]  prescaler_select_field_reg;
  reg  [1:0]  state_reg;
  reg  [15:0] ck_count_reg;
  reg  [15:0] ck_target_reg;
  reg  [13:0] ms_count_reg;
  reg  [1:0]  ms_sel_reg;
  reg  [3:0]  active_sel_reg;
  reg         reserved_cfg_reg;
  reg         stall_reg;
  reg  [1:0]  xtal_range_reg;
  reg         domain_en_reg;
  reg         ack_reg;
  reg  [31:0] dat_reg;
  reg         restart_reg;

  wire [3:0] clock_source_select_fuses;
  wire [1:0] startup_time_fuses;
  wire       divide_by_eight_fuse;
  wire       reset_pin_disable_fuse;
  wire       src_tick;
  wire       presc_tick;
  wire       bus_req;

  // Fuse bits read 0 when programmed.
  assign clock_source_select_fuses = fuse_reg[`FUSE_SRC_SEL_LSB +: 4];
  assign startup_time_fuses        = fuse_reg[`FUSE_STARTUP_LSB +: 2];
  assign divide_by_eight_fuse      = fuse_reg[`FUSE_DIV8_BIT];
  assign reset_pin_disable_fuse    = fuse_reg[`FUSE_RSTDIS_BIT];
  assign bus_req                   = wb_cyc_i & wb_stb_i & ~ack_reg;

  // Wake count, reset 14CK flag, millisecond choice and validity per fuse setting.
  reg [15:0] tbl_wake;
  reg        tbl_add14;
  reg [1:0]  tbl_ms;
  reg        tbl_bad;
  always @* begin
    tbl_wake  = `CK_WAKE_6;
    tbl_add14 = 1'b1;
    tbl_ms    = `MS_64;
    tbl_bad   = 1'b0;
    if (clock_source_select_fuses[3]) begin
      if (!clock_source_select_fuses[0]) begin
        case (startup_time_fuses)
          2'b00: begin
            tbl_wake = `CK_WAKE_258;
            tbl_ms   = `MS_4;
          end
          2'b01: begin
            tbl_wake = `CK_WAKE_258;
            tbl_ms   = `MS_64;
          end
          2'b10: begin
            tbl_wake = `CK_WAKE_1K;
            tbl_ms   = `MS_NONE;
          end
          default: begin
            tbl_wake = `CK_WAKE_1K;
            tbl_ms   = `MS_4;
          end
        endcase
      end else begin
        case (startup_time_fuses)
          2'b00: begin
            tbl_wake = `CK_WAKE_1K;
            tbl_ms   = `MS_64;
          end
          2'b01: begin
            tbl_wake = `CK_WAKE_16K;
            tbl_ms   = `MS_NONE;
          end
          2'b10: begin
            tbl_wake = `CK_WAKE_16K;
            tbl_ms   = `MS_4;
          end
          default: begin
            tbl_wake = `CK_WAKE_16K;
            tbl_ms   = `MS_64;
          end
        endcase
      end
    end else if (clock_source_select_fuses == `SRC_SEL_LF_XTAL) begin
      tbl_add14 = 1'b0;
      case (startup_time_fuses)
        2'b00: begin
          tbl_wake = `CK_WAKE_1K;
          tbl_ms   = `MS_4;
        end
        2'b01: begin
          tbl_wake = `CK_WAKE_1K;
          tbl_ms   = `MS_64;
        end
        2'b10: begin
          tbl_wake = `CK_WAKE_32K;
          tbl_ms   = `MS_64;
        end
        default: begin
          tbl_wake = `CK_WAKE_32K;
          tbl_bad  = 1'b1;
        end
      endcase
    end else if (clock_source_select_fuses == `SRC_SEL_OSC128K ||
                 clock_source_select_fuses == `SRC_SEL_RC8M ||
                 clock_source_select_fuses == `SRC_SEL_EXTERNAL) begin
      case (startup_time_fuses)
        2'b00: tbl_ms = reset_pin_disable_fuse ? `MS_NONE : `MS_4;
        2'b01: tbl_ms = `MS_4;
        2'b10: tbl_ms = `MS_64;
        default: tbl_bad = 1'b1;
      endcase
    end else begin
      tbl_bad = 1'b1;
    end
  end

  // The selected source paces every CK count and the prescaler input.
  assign src_tick =
    (active_sel_reg[3])                    ? xtal_tick :
    (active_sel_reg == `SRC_SEL_OSC128K)   ? osc128k_tick :
    (active_sel_reg == `SRC_SEL_LF_XTAL)   ? lf_xtal_tick :
    (active_sel_reg == `SRC_SEL_EXTERNAL)  ? ext_clk_tick :
                                             rc8m_tick;

  system_prescaler u_prescaler (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .src_tick (src_tick),
    .sel      (prescaler_select_field_reg),
    .tick_reg (presc_tick)
  );

  // Start-up sequencer. Fuses are sampled only when a sequence begins, so a
  // fuse write takes effect at the next restart, and its wake count at the next wake.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg                  <= ST_CK;
      ck_count_reg               <= 16'h0000;
      ck_target_reg              <= 16'h0000;
      ms_count_reg               <= 14'h0000;
      ms_sel_reg                 <= `MS_NONE;
      active_sel_reg             <= `SRC_SEL_RC8M;
      reserved_cfg_reg           <= 1'b0;
      stall_reg                  <= 1'b1;
      xtal_range_reg             <= 2'b00;
      prescaler_select_field_reg <= `PRESCALE_DIV8;
      restart_reg                <= 1'b1;
    end else if (ce) begin
      if (restart_reg) begin
        // Reset entry: wake count plus 14CK where listed, then milliseconds.
        restart_reg      <= 1'b0;
        state_reg        <= ST_CK;
        stall_reg        <= 1'b1;
        active_sel_reg   <= clock_source_select_fuses;
        xtal_range_reg   <= clock_source_select_fuses[2:1];
        ck_count_reg     <= 16'h0000;
        ck_target_reg    <= tbl_wake + (tbl_add14 ? `CK_RESET_14 : 16'h0000);
        ms_sel_reg       <= tbl_ms;
        ms_count_reg     <= 14'h0000;
        reserved_cfg_reg <= tbl_bad;
        prescaler_select_field_reg <= divide_by_eight_fuse ? `PRESCALE_DIV1
                                                           : `PRESCALE_DIV8;
      end else if (state_reg == ST_RUN && wake_req) begin
        // Wake from power-down or power-save counts only clock cycles.
        state_reg     <= ST_CK;
        stall_reg     <= 1'b1;
        ck_count_reg  <= 16'h0000;
        ck_target_reg <= tbl_wake;
        ms_sel_reg    <= `MS_NONE;
      end else if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PRESCALE_OFFSET) begin
        prescaler_select_field_reg <= wb_dat_i[3:0];
      end else if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `CONTROL_OFFSET
                   && wb_dat_i[0]) begin
        restart_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_CK: begin
            if (ck_count_reg >= ck_target_reg) begin
              if (ms_sel_reg == `MS_NONE) begin
                state_reg <= ST_RUN;
                stall_reg <= 1'b0;
              end else begin
                state_reg <= ST_MS;
              end
            end else if (src_tick) begin
              ck_count_reg <= ck_count_reg + 16'h0001;
            end
          end
          ST_MS: begin
            if (ms_count_reg >= ((ms_sel_reg == `MS_4) ? `WDT_CYCLES_4MS
                                                       : `WDT_CYCLES_64MS)) begin
              state_reg <= ST_RUN;
              stall_reg <= 1'b0;
            end else if (wdt_osc_tick) begin
              ms_count_reg <= ms_count_reg + 14'h0001;
            end
          end
          ST_RUN: begin
            stall_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_RUN;
          end
        endcase
      end
    end
  end

  // One prescaled enable feeds every domain; held low while the core stalls.
  // A starting sequence also gates it, so no pulse slips out as stall rises.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      domain_en_reg <= 1'b0;
    end else if (ce) begin
      domain_en_reg <= presc_tick & ~stall_reg & ~restart_reg
                       & ~(state_reg == ST_RUN && wake_req);
    end
  end

  // Fuse image, writable from software to emulate fuse programming.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_reg <= `FUSE_SHIPPED;
    end else if (ce) begin
      if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `FUSE_OFFSET) begin
        fuse_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Wishbone slave: ack one cycle after the request, dropped the next cycle.
  // Unmapped addresses are acknowledged and read as zero.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (ce) begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `FUSE_OFFSET:     dat_reg <= {24'h000000, fuse_reg};
          `PRESCALE_OFFSET: dat_reg <= {28'h0000000, prescaler_select_field_reg};
          `STATUS_OFFSET:   dat_reg <= {20'h00000, active_sel_reg, 3'h0,
                                        reserved_cfg_reg, ms_sel_reg,
                                        state_reg == ST_MS, stall_reg};
          default:          dat_reg <= 32'h00000000;
        endcase
      end else begin
        dat_reg <= 32'h00000000;
      end
    end
  end

  assign wb_dat_o                    = dat_reg;
  assign wb_ack_o                    = ack_reg;
  assign core_stall                  = stall_reg;
  assign xtal_range                  = xtal_range_reg;
  assign core_domain_clock           = domain_en_reg;
  assign io_domain_clock             = domain_en_reg;
  assign converter_domain_clock      = domain_en_reg;
  assign program_memory_domain_clock = domain_en_reg;

endmodule // clock_source_startup_sequencer
`default_nettype wire

// [bench/startup_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module startup_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wake_req,
  input wire logic        core_stall,
  input wire logic [1:0]  xtal_range,
  input wire logic        core_domain_clock,
  input wire logic        io_domain_clock,
  input wire logic        converter_domain_clock,
  input wire logic        program_memory_domain_clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A restart write as the slave takes it.
  wire restart = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == 4'h8 && wb_dat_i[0];

  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  chk_ack_answer:
    assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  chk_dat_idle:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not idle");
  chk_domains_equal:
    assert property (core_domain_clock == io_domain_clock
      && core_domain_clock == converter_domain_clock
      && core_domain_clock == program_memory_domain_clock) else $error("domains differ");
  chk_stall_gates:
    assert property (core_stall |-> !core_domain_clock) else $error("clock while stalled");
  chk_reset_hold:
    assert property ($rose(rst_b) |-> core_stall [*8]) else $error("reset delay short");
  chk_restart_stall:
    assert property (restart |-> ##[1:3] core_stall) else $error("restart not stalled");
  chk_wake_stall:
    assert property (ce && wake_req && !core_stall |-> ##[1:3] core_stall)
    else $error("wake not stalled");
  chk_min_stall:
    assert property ($rose(core_stall) |-> core_stall [*6]) else $error("stall too short");
  chk_range_hold:
    assert property (!core_stall ##1 !core_stall |-> $stable(xtal_range))
    else $error("range moved");

  cover property ($fell(core_stall));
  cover property (restart);
  cover property (wake_req && !core_stall);
endmodule // startup_sva

bind clock_source_startup_sequencer startup_sva i_sva (
  .clk                         (clk),
  .rst_b                       (rst_b),
  .ce                          (ce),
  .wb_cyc_i                    (wb_cyc_i),
  .wb_stb_i                    (wb_stb_i),
  .wb_we_i                     (wb_we_i),
  .wb_adr_i                    (wb_adr_i),
  .wb_sel_i                    (wb_sel_i),
  .wb_dat_i                    (wb_dat_i),
  .wb_dat_o                    (wb_dat_o),
  .wb_ack_o                    (wb_ack_o),
  .wake_req                    (wake_req),
  .core_stall                  (core_stall),
  .xtal_range                  (xtal_range),
  .core_domain_clock           (core_domain_clock),
  .io_domain_clock             (io_domain_clock),
  .converter_domain_clock      (converter_domain_clock),
  .program_memory_domain_clock (program_memory_domain_clock)
);
`default_nettype wire

// [bench/crystal_model.sv]
`timescale 1ns/10ps
`default_nettype none
module crystal_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] period,
  output var  logic       xtal_tick
);
  logic [3:0] cnt_reg;

  // One pulse per resonator cycle; a slow part is just a longer period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg   <= 4'h0;
      xtal_tick <= 1'b0;
    end else begin
      xtal_tick <= (cnt_reg == 4'h0);
      cnt_reg   <= (cnt_reg + 4'h1 >= period) ? 4'h0 : cnt_reg + 4'h1;
    end
  end
endmodule // crystal_model
`default_nettype wire

// [bench/tb_clock_source_startup_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_clock_source_startup_sequencer;
  logic        clk, rst_b, ce, cyc, stb, we, wake_req, ost, lft, ack, stall, tick, dom;
  logic [3:0]  adr, per;
  logic [31:0] dat, rd, dout;
  logic [1:0]  rng, range_pick;
  int          mismatches, tests_run, cnt, t, r;

  clock_source_startup_sequencer i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .osc128k_tick(ost), .lf_xtal_tick(lft), .xtal_tick(tick), .rc8m_tick(1'b1),
    .ext_clk_tick(1'b1), .wdt_osc_tick(1'b1), .wake_req(wake_req), .core_stall(stall),
    .xtal_range(rng), .core_domain_clock(dom), .io_domain_clock(),
    .converter_domain_clock(), .program_memory_domain_clock());

  crystal_model i_xtal (.clk(clk), .rst_b(rst_b), .period(per), .xtal_tick(tick));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Slow sources tick at their own rates so a wrong source pick shows in the timing.
  always @(posedge clk) begin
    cnt <= cnt + 1;
    ost <= (cnt % 2 == 0);
    lft <= (cnt % 3 == 0);
  end

  task automatic end_of_test;
    $display("Counts: %0d mismatches, %0d tests", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, lo, hi);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  // Only the watchdog ends a wait that never sees ack.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dout;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic wait_stall(input int skip);
    repeat (skip) @(posedge clk);
    t = skip;
    while (stall !== 1'b0 && t < 40000) begin
      @(posedge clk);
      t++;
    end
  endtask

  // Reference start-up: n source ticks of period p, then m watchdog cycles.
  function automatic void model(input logic [7:0] f, output int n, m, p);
    logic [1:0] s;
    s = f[5:4];
    n = 20;
    p = (f[3:0] == 4'h3) ? 2 : 1;
    m = (s == 2'h1) ? 512 : (s == 2'h2) ? 8192 : 0;
    if (f[3:0] < 4'h4 && s == 2'h0 && !f[7]) m = 512;
    if (f[3:0] == 4'h4) begin
      p = 3;
      n = (s == 2'h2) ? 32768 : 1024;
      m = (s == 2'h0) ? 512 : 8192;
    end
    if (f[3]) begin
      p = 2;
      n = 14 + (f[0] ? ((s == 2'h0) ? 1024 : 16384) : (s[1] ? 1024 : 258));
      m = (s == 2'h0 || s == 2'h3) ? (f[0] ? 8192 : 512)
        : (s == 2'h1) ? (f[0] ? 0 : 8192) : (f[0] ? 512 : 0);
    end
  endfunction

  task automatic run(input logic [7:0] f);
    int n, m, p;
    model(f, n, m, p);
    wb(1'b1, 4'h0, {24'h0, f});
    wb(1'b1, 4'h8, 32'h1);
    wait_stall(3);
    chk_rng(t, n * p + m - p, n * p + m + p + 6);
    if (f[3]) chk_val({30'h0, rng}, {30'h0, f[2:1]});
  endtask

  task automatic count_dom;
    repeat (16) @(posedge clk);
    t = 0;
    repeat (256) begin
      @(posedge clk);
      if (dom === 1'b1) t++;
    end
  endtask

  // A hang costs a mismatch and still reaches the verdict.
  initial begin
    #450000;
    mismatches++;
    end_of_test();
  end

  initial begin
    {cyc, stb, we, wake_req, ost, lft} = 6'h00;
    {adr, dat, cnt, mismatches, tests_run} = '0;
    per = 4'h2;
    ce = 1'b1;
    rst_b = 1'b0;
    void'($urandom(39373));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wait_stall(0);
    chk_rng(t, 8211, 8219);
    wb(1'b0, 4'h0, 32'h0);
    chk_val(rd, 32'hA2);
    wb(1'b0, 4'h4, 32'h0);
    chk_val(rd, 32'h3);
    wb(1'b0, 4'h2, 32'h0);
    chk_val(rd, 32'h0);
    wb(1'b0, 4'hC, 32'h0);
    chk_val(rd & 32'h1, 32'h0);
    count_dom();
    chk_rng(t, 31, 33);
    r = $urandom % 5;
    wb(1'b1, 4'h4, r);
    count_dom();
    chk_rng(t, (256 >> r) - 1, (256 >> r) + 1);
    run(8'hC3);
    // Twenty cycles with the clock enable low must freeze the wake count.
    wake_req <= 1'b1;
    @(posedge clk);
    {wake_req, ce} <= 2'b00;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wait_stall(0);
    chk_rng(t, 10, 20);
    run(8'h43);
    run(8'hD3);
    run(8'hC4);
    run(8'hD4);
    range_pick = 2'($urandom);
    run({4'hC, 1'b1, range_pick, 1'b0});
    run({4'hE, 1'b1, range_pick, 1'b0});
    run({4'hD, 1'b1, range_pick, 1'b1});
    end_of_test();
  end
endmodule // tb_clock_source_startup_sequencer
`default_nettype wire
